// >>> design/timer8_pkg.sv
// shared constants and types for the 8-bit asynchronous timer block
package timer8_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_IRQ_FLAGS = 8'h37;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h70;
	localparam logic [7:0] IDX_CTRL_A = 8'hb0;
	localparam logic [7:0] IDX_CTRL_B = 8'hb1;
	localparam logic [7:0] IDX_COUNTER = 8'hb2;
	localparam logic [7:0] IDX_CMP_A = 8'hb3;
	localparam logic [7:0] IDX_CMP_B = 8'hb4;
	localparam logic [7:0] IDX_ASYNC_STATUS = 8'hb6;
	localparam logic [7:0] IDX_AUX_CTRL = 8'hb8;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_FORCE_A = 7;
	localparam int BIT_FORCE_B = 6;
	localparam int BIT_WAVE_HI = 3;
	localparam int BIT_EXT_CLK_EN = 6;
	localparam int BIT_ASYNC_SEL = 5;
	localparam int BIT_CMP_B_IRQ_EN = 2;
	localparam int BIT_CMP_A_IRQ_EN = 1;
	localparam int BIT_CMP_B_FLAG = 2;
	localparam int BIT_CMP_A_FLAG = 1;
	localparam int BIT_GLOBAL_IRQ = 0;
	localparam int BIT_EXT_PIN_CLK = 1;

	// busy flag positions within async_status
	localparam int UB_COUNTER = 4;
	localparam int UB_CMP_A = 3;
	localparam int UB_CMP_B = 2;
	localparam int UB_CTRL_A = 1;
	localparam int UB_CTRL_B = 0;

	// ----------------------------------------------------------------
	// reset values and fixed counts
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [7:0] MAX_COUNT = 8'hff;
	localparam logic [7:0] BOTTOM = 8'h00;
	localparam int PRESC_WIDTH = 10;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// ----------------------------------------------------------------
	// waveform modes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		WM_NORMAL = 3'b000,
		WM_PC_FF = 3'b001,
		WM_CTC = 3'b010,
		WM_FAST_FF = 3'b011,
		WM_RSVD4 = 3'b100,
		WM_PC_OCRA = 3'b101,
		WM_RSVD6 = 3'b110,
		WM_FAST_OCRA = 3'b111
	} wave_mode_type;

	// latched ahb address phase
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] index;
	} bus_req_type;

endpackage

// >>> design/async_timer8_control_regs.sv
// 8-bit timer with two compare channels, async source and ahb-lite registers
`timescale 1ns/10ps
// What this block does
// - force A strobe updates output A, non-PWM only
// - force B strobe updates output B, non-PWM only
// - forced compare sets no flag, no clear
// - force bits and bits 5:4 read zero
// - clk_sel stops, passes, or divides source
// - counter write blocks next compare match
// - compares run continuously against counter
// - external clock replaces crystal when enabled
// - async_clock_sel picks io or oscillator clock
// - async writes set per-register busy flags
// - counter reads live, others read storage
// - compare B interrupt needs enable and global
// - compare A interrupt needs enable and global
// - external pin edges count regardless of direction
// - ctrl B bit 3 is wave mode top
// - wave mode selects normal, PWM or CTC
// - match flags cleared by vector or one
module async_timer8_control_regs
	import timer8_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// ahb-lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// pins
	input wire logic i_timer_osc_in_pin,
	input wire logic i_ext_count_pin,
	output logic o_wave_out_a,
	output logic o_wave_out_b,
	output logic o_crystal_osc_en,
	// interrupt requests and vector acknowledges
	input wire logic i_cmp_a_vector_ack,
	input wire logic i_cmp_b_vector_ack,
	output logic o_cmp_a_irq,
	output logic o_cmp_b_irq
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic is_pwm(input logic [2:0] m);
		is_pwm = m[0];
	endfunction

	function automatic logic [PRESC_WIDTH-1:0] div_mask(input logic [2:0] sel);
		case (sel)
			3'h2: div_mask = 10'h007;
			3'h3: div_mask = 10'h01f;
			3'h4: div_mask = 10'h03f;
			3'h5: div_mask = 10'h07f;
			3'h6: div_mask = 10'h0ff;
			3'h7: div_mask = 10'h3ff;
			default: div_mask = 10'h000;
		endcase
	endfunction

	// new output level on a compare event for non-PWM modes
	function automatic logic match_action(input logic [1:0] om, input logic cur);
		case (om)
			2'b01: match_action = ~cur;
			2'b10: match_action = 1'b0;
			2'b11: match_action = 1'b1;
			default: match_action = cur;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] rst_sync;
	logic rst_n;
	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	logic [2:0] osc_sync;
	logic [2:0] pin_sync;
	logic osc_level;
	logic pin_level;
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			osc_sync <= 3'b000;
			pin_sync <= 3'b000;
			osc_level <= 1'b0;
			pin_level <= 1'b0;
		end
		else
		begin
			osc_sync <= {osc_sync[1:0], i_timer_osc_in_pin};
			pin_sync <= {pin_sync[1:0], i_ext_count_pin};
			if (osc_sync[1] == osc_sync[2])
				osc_level <= osc_sync[2];
			if (pin_sync[1] == pin_sync[2])
				pin_level <= pin_sync[2];
		end
	end

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	logic [7:0] ctrl_a_tmp, ctrl_b_tmp, cmp_a_tmp, cmp_b_tmp, counter_tmp;
	logic [7:0] ctrl_a, ctrl_b, cmp_a, cmp_b, counter;
	logic [7:0] irq_mask;
	logic ext_clock_in_en, async_clock_sel;
	logic global_irq_en, ext_pin_clk_en;
	logic [4:0] upd_busy;
	logic cmp_a_match_flag, cmp_b_match_flag;
	logic force_a_pend, force_b_pend;

	bus_req_type req;
	logic wr_go;
	logic [7:0] wdat;
	assign wr_go = req.valid & req.write;
	assign wdat = i_hwdata[7:0];

	// ----------------------------------------------------------------
	// timer source clock events
	// ----------------------------------------------------------------
	logic osc_prev, pin_prev;
	logic src_event;
	logic [PRESC_WIDTH-1:0] presc;
	logic tick;
	logic [2:0] wave_mode;
	logic [2:0] clk_sel;
	assign clk_sel = ctrl_b[2:0];
	assign wave_mode = {ctrl_b[BIT_WAVE_HI], ctrl_a[1:0]};

	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			osc_prev <= 1'b0;
			pin_prev <= 1'b0;
		end
		else
		begin
			osc_prev <= osc_level;
			pin_prev <= pin_level;
		end
	end

	assign src_event = async_clock_sel ? (osc_level & ~osc_prev) : 1'b1;

	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			presc <= '0;
		else if (src_event)
			presc <= presc + 10'h001;
	end

	// pin edges count whatever the pin direction
	always_comb
	begin
		if (ext_pin_clk_en)
			tick = pin_level & ~pin_prev;
		else if (clk_sel == 3'h0)
			tick = 1'b0;
		else
			tick = src_event & ((presc & div_mask(clk_sel)) == div_mask(clk_sel));
	end

	// transfer point into the timer domain
	logic xfer;
	assign xfer = async_clock_sel ? src_event : 1'b1;

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			req <= '0;
		else if (i_hready)
		begin
			req.valid <= i_hsel & i_htrans[1] & (i_haddr[1:0] == 2'b00);
			req.write <= i_hwrite;
			req.index <= i_haddr[9:2];
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_hrdata <= RST_WORD;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end
		else
		begin
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
			if (i_hready & i_hsel & i_htrans[1] & ~i_hwrite)
			begin
				// force bits and reserved read zero
				case (i_haddr[9:2])
					IDX_IRQ_FLAGS: o_hrdata <= {29'h0, cmp_b_match_flag, cmp_a_match_flag, 1'b0};
					IDX_IRQ_MASK: o_hrdata <= {24'h0, irq_mask};
					IDX_CTRL_A: o_hrdata <= {24'h0, ctrl_a_tmp};
					IDX_CTRL_B: o_hrdata <= {28'h0, ctrl_b_tmp[3:0]};
					IDX_COUNTER: o_hrdata <= {24'h0, counter};
					IDX_CMP_A: o_hrdata <= {24'h0, cmp_a_tmp};
					IDX_CMP_B: o_hrdata <= {24'h0, cmp_b_tmp};
					IDX_ASYNC_STATUS: o_hrdata <= {25'h0, ext_clock_in_en, async_clock_sel, upd_busy};
					IDX_AUX_CTRL: o_hrdata <= {30'h0, ext_pin_clk_en, global_irq_en};
					default: o_hrdata <= RST_WORD;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// software-side storage registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_a_tmp <= RST_REG;
			ctrl_b_tmp <= RST_REG;
			cmp_a_tmp <= RST_REG;
			cmp_b_tmp <= RST_REG;
			counter_tmp <= RST_REG;
			irq_mask <= RST_REG;
			ext_clock_in_en <= 1'b0;
			async_clock_sel <= 1'b0;
			global_irq_en <= 1'b0;
			ext_pin_clk_en <= 1'b0;
		end
		else if (wr_go)
		begin
			case (req.index)
				IDX_CTRL_A: ctrl_a_tmp <= wdat;
				IDX_CTRL_B: ctrl_b_tmp <= {4'h0, wdat[3:0]};
				IDX_CMP_A: cmp_a_tmp <= wdat;
				IDX_CMP_B: cmp_b_tmp <= wdat;
				IDX_COUNTER: counter_tmp <= wdat;
				IDX_IRQ_MASK: irq_mask <= {5'h0, wdat[2:0]};
				IDX_ASYNC_STATUS:
				begin
					ext_clock_in_en <= wdat[BIT_EXT_CLK_EN];
					async_clock_sel <= wdat[BIT_ASYNC_SEL];
				end
				IDX_AUX_CTRL:
				begin
					global_irq_en <= wdat[BIT_GLOBAL_IRQ];
					ext_pin_clk_en <= wdat[BIT_EXT_PIN_CLK];
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// update-busy flags and pending transfers
	// ----------------------------------------------------------------
	logic [4:0] wr_hit;
	logic cnt_pend;
	always_comb
	begin
		wr_hit = 5'h00;
		if (wr_go)
		begin
			wr_hit[UB_COUNTER] = (req.index == IDX_COUNTER);
			wr_hit[UB_CMP_A] = (req.index == IDX_CMP_A);
			wr_hit[UB_CMP_B] = (req.index == IDX_CMP_B);
			wr_hit[UB_CTRL_A] = (req.index == IDX_CTRL_A);
			wr_hit[UB_CTRL_B] = (req.index == IDX_CTRL_B);
		end
	end

	// busy set on write, cleared on transfer
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			upd_busy <= 5'h00;
		else if (!async_clock_sel)
			upd_busy <= 5'h00;
		else
			upd_busy <= wr_hit | (upd_busy & {5{~xfer}});
	end

	// pending work for the timer side; a new write wins over the transfer
	logic [4:0] pend;
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pend <= 5'h00;
			force_a_pend <= 1'b0;
			force_b_pend <= 1'b0;
		end
		else
		begin
			pend <= wr_hit | (pend & {5{~xfer}});
			if (wr_hit[UB_CTRL_B])
			begin
				force_a_pend <= wdat[BIT_FORCE_A];
				force_b_pend <= wdat[BIT_FORCE_B];
			end
			else if (xfer)
			begin
				force_a_pend <= 1'b0;
				force_b_pend <= 1'b0;
			end
		end
	end
	assign cnt_pend = pend[UB_COUNTER] & xfer;

	// storage moves into live copies at transfer
	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_a <= RST_REG;
			ctrl_b <= RST_REG;
			cmp_a <= RST_REG;
			cmp_b <= RST_REG;
		end
		else if (xfer)
		begin
			if (pend[UB_CTRL_A])
				ctrl_a <= ctrl_a_tmp;
			if (pend[UB_CTRL_B])
				ctrl_b <= ctrl_b_tmp;
			if (pend[UB_CMP_A])
				cmp_a <= cmp_a_tmp;
			if (pend[UB_CMP_B])
				cmp_b <= cmp_b_tmp;
		end
	end

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	logic [7:0] top;
	logic count_down;
	logic block_match;
	logic match_a, match_b;
	logic fire_a, fire_b;

	always_comb
	begin
		case (wave_mode)
			WM_CTC, WM_PC_OCRA, WM_FAST_OCRA: top = cmp_a;
			default: top = MAX_COUNT;
		endcase
	end

	assign match_a = (counter == cmp_a);
	assign match_b = (counter == cmp_b);
	assign fire_a = tick & match_a & ~block_match;
	assign fire_b = tick & match_b & ~block_match;

	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			block_match <= 1'b0;
		else if (cnt_pend)
			block_match <= 1'b1;
		else if (tick)
			block_match <= 1'b0;
	end

	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			counter <= RST_REG;
			count_down <= 1'b0;
		end
		else if (cnt_pend)
			counter <= counter_tmp;
		else if (tick)
		begin
			case (wave_mode)
				WM_PC_FF, WM_PC_OCRA:
				begin
					if (!count_down && counter >= top)
					begin
						count_down <= 1'b1;
						counter <= counter - 8'h01;
					end
					else if (count_down && counter == BOTTOM)
					begin
						count_down <= 1'b0;
						counter <= counter + 8'h01;
					end
					else if (count_down)
						counter <= counter - 8'h01;
					else
						counter <= counter + 8'h01;
				end
				WM_CTC, WM_FAST_FF, WM_FAST_OCRA:
				begin
					count_down <= 1'b0;
					counter <= (counter == top) ? BOTTOM : counter + 8'h01;
				end
				default:
				begin
					count_down <= 1'b0;
					counter <= counter + 8'h01;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// waveform outputs
	// ----------------------------------------------------------------
	logic [1:0] out_mode_a, out_mode_b;
	logic force_a, force_b;
	assign out_mode_a = ctrl_a[7:6];
	assign out_mode_b = ctrl_a[5:4];
	assign force_a = xfer & force_a_pend & ~is_pwm(ctrl_b_tmp[BIT_WAVE_HI] ? 3'b101 : {1'b0, ctrl_a_tmp[1:0]});
	assign force_b = xfer & force_b_pend & ~is_pwm(ctrl_b_tmp[BIT_WAVE_HI] ? 3'b101 : {1'b0, ctrl_a_tmp[1:0]});

	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_wave_out_a <= 1'b0;
			o_wave_out_b <= 1'b0;
		end
		else if (!is_pwm(wave_mode))
		begin
			if (force_a | fire_a)
				o_wave_out_a <= match_action(out_mode_a, o_wave_out_a);
			if (force_b | fire_b)
				o_wave_out_b <= match_action(out_mode_b, o_wave_out_b);
		end
		else if (wave_mode[1])
		begin
			// fast pwm: set or clear at bottom, opposite at match
			if (tick && counter == top)
			begin
				o_wave_out_a <= out_mode_a[1] ? ~out_mode_a[0] : o_wave_out_a;
				o_wave_out_b <= out_mode_b[1] ? ~out_mode_b[0] : o_wave_out_b;
			end
			else
			begin
				if (fire_a)
					o_wave_out_a <= out_mode_a[1] ? out_mode_a[0] :
						(out_mode_a[0] & wave_mode[2]) ? ~o_wave_out_a : o_wave_out_a;
				if (fire_b && out_mode_b[1])
					o_wave_out_b <= out_mode_b[0];
			end
		end
		else
		begin
			// phase correct: direction chooses set or clear
			if (fire_a)
				o_wave_out_a <= out_mode_a[1] ? (out_mode_a[0] ^ count_down) :
					(out_mode_a[0] & wave_mode[2]) ? ~o_wave_out_a : o_wave_out_a;
			if (fire_b && out_mode_b[1])
				o_wave_out_b <= out_mode_b[0] ^ count_down;
		end
	end

	// ----------------------------------------------------------------
	// match flags and interrupt requests
	// ----------------------------------------------------------------
	logic clr_flag_a, clr_flag_b;
	assign clr_flag_a = i_cmp_a_vector_ack | (wr_go && req.index == IDX_IRQ_FLAGS && wdat[BIT_CMP_A_FLAG]);
	assign clr_flag_b = i_cmp_b_vector_ack | (wr_go && req.index == IDX_IRQ_FLAGS && wdat[BIT_CMP_B_FLAG]);

	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmp_a_match_flag <= 1'b0;
			cmp_b_match_flag <= 1'b0;
		end
		else
		begin
			cmp_a_match_flag <= fire_a | (cmp_a_match_flag & ~clr_flag_a);
			cmp_b_match_flag <= fire_b | (cmp_b_match_flag & ~clr_flag_b);
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_cmp_a_irq <= 1'b0;
			o_cmp_b_irq <= 1'b0;
			o_crystal_osc_en <= 1'b0;
		end
		else
		begin
			o_cmp_a_irq <= cmp_a_match_flag & irq_mask[BIT_CMP_A_IRQ_EN] & global_irq_en;
			o_cmp_b_irq <= cmp_b_match_flag & irq_mask[BIT_CMP_B_IRQ_EN] & global_irq_en;
			o_crystal_osc_en <= async_clock_sel & ~ext_clock_in_en;
		end
	end

endmodule // async_timer8_control_regs

// >>> bench/async_timer8_control_regs_monitor.sv
// assertion checker for the 8-bit timer register block
`timescale 1ns/10ps
module async_timer8_control_regs_monitor
	import timer8_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	// ahb-lite
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	input wire logic [31:0] o_hrdata,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	// pins and interrupts
	input wire logic o_crystal_osc_en,
	input wire logic i_cmp_a_vector_ack,
	input wire logic i_cmp_b_vector_ack,
	input wire logic o_cmp_a_irq,
	input wire logic o_cmp_b_irq
);
	logic rd_phase;
	logic mapped;
	logic wr_status;

	// ----------------------------------------------------------------
	// address phase decode
	// ----------------------------------------------------------------
	assign rd_phase = i_hsel & i_htrans[1] & i_hready & ~i_hwrite;
	assign mapped = i_haddr[9:2] inside {IDX_IRQ_FLAGS, IDX_IRQ_MASK, IDX_CTRL_A, IDX_CTRL_B, IDX_COUNTER,
		IDX_CMP_A, IDX_CMP_B, IDX_ASYNC_STATUS, IDX_AUX_CTRL};

	always_ff @(posedge i_ref_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			wr_status <= 1'b0;
		else
			wr_status <= i_hsel & i_htrans[1] & i_hready & i_hwrite & (i_haddr[9:2] == IDX_ASYNC_STATUS);
	end

	default clocking @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	chk_ready_high: assert property (o_hreadyout) else $error("hreadyout low");
	chk_resp_okay: assert property (!o_hresp) else $error("hresp not okay");
	chk_upper_zero: assert property (rd_phase |=> o_hrdata[31:8] == 24'h0) else $error("upper read bits set");
	chk_ctrlb_high_zero:
		assert property (rd_phase && i_haddr[9:2] == IDX_CTRL_B |=> o_hrdata[7:4] == 4'h0)
		else $error("force or reserved bits read nonzero");
	chk_unmapped_zero:
		assert property (rd_phase && !mapped |=> o_hrdata == 32'h0) else $error("unmapped read nonzero");
	// write data stands at the edge where wr_status is seen; enable follows two edges later
	chk_crystal_follows:
		assert property (wr_status |-> ##2 o_crystal_osc_en == ($past(i_hwdata[BIT_ASYNC_SEL], 2)
			& !$past(i_hwdata[BIT_EXT_CLK_EN], 2))) else $error("crystal enable wrong");
	chk_ack_clears_a:
		assert property (i_cmp_a_vector_ack |-> ##[1:3] !o_cmp_a_irq) else $error("irq a not cleared");
	chk_ack_clears_b:
		assert property (i_cmp_b_vector_ack |-> ##[1:3] !o_cmp_b_irq) else $error("irq b not cleared");

	cov_irq_a: cover property ($rose(o_cmp_a_irq));
	cov_irq_b: cover property ($rose(o_cmp_b_irq));
	cov_crystal: cover property ($rose(o_crystal_osc_en));
endmodule // async_timer8_control_regs_monitor

bind async_timer8_control_regs async_timer8_control_regs_monitor mon (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
	.i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
	.i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
	.o_crystal_osc_en(o_crystal_osc_en), .i_cmp_a_vector_ack(i_cmp_a_vector_ack),
	.i_cmp_b_vector_ack(i_cmp_b_vector_ack), .o_cmp_a_irq(o_cmp_a_irq), .o_cmp_b_irq(o_cmp_b_irq));

// >>> bench/async_timer8_control_regs_bench.sv
// self-checking bench for the 8-bit timer register block
`timescale 1ns/10ps
module async_timer8_control_regs_bench
	import timer8_pkg::*;
;
	logic ref_clk, rst_n, hwrite, osc_pin, cnt_pin, ack_a, ack_b;
	logic hreadyout, hresp, wave_a, wave_b, xtal, irq_a, irq_b;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd, hold;
	int n_errors, tests_run;
	int divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};

	async_timer8_control_regs dut (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_hsel(1'b1), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hreadyout),
		.o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp), .i_timer_osc_in_pin(osc_pin),
		.i_ext_count_pin(cnt_pin), .o_wave_out_a(wave_a), .o_wave_out_b(wave_b), .o_crystal_osc_en(xtal),
		.i_cmp_a_vector_ack(ack_a), .i_cmp_b_vector_ack(ack_b), .o_cmp_a_irq(irq_a), .o_cmp_b_irq(irq_b));

	// ----------------------------------------------------------------
	// bus and check tasks
	// ----------------------------------------------------------------
	task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge ref_clk);
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {22'h0, idx, 2'b00};
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		rd = hrdata;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, {24'h0, d});
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		chk(rd, exp);
	endtask

	task automatic rng(input logic [7:0] idx, input logic [7:0] lo, input logic [7:0] hi);
		bus(1'b0, idx, 32'h0);
		tests_run++;
		if ($isunknown(rd) || rd > {24'h0, hi} || rd < {24'h0, lo})
		begin
			$display("[FAIL] t=%0t got=%h exp=%h..%h", $time, rd, lo, hi);
			n_errors++;
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic edges(input bit osc, input int n);
		repeat (n)
		begin
			if (osc)
				osc_pin <= 1'b1;
			else
				cnt_pin <= 1'b1;
			wait_n(16);
			osc_pin <= 1'b0;
			cnt_pin <= 1'b0;
			wait_n(16);
		end
	endtask

	task automatic ack(input bit b);
		@(posedge ref_clk);
		ack_a <= !b;
		ack_b <= b;
		@(posedge ref_clk);
		ack_a <= 1'b0;
		ack_b <= 1'b0;
	endtask

	task conclude;
		if (n_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// clock, watchdog and tests
	// ----------------------------------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	initial
	begin
		wait_n(60000);
		n_errors++;
		conclude();
	end

	initial
	begin
		{rst_n, hwrite, osc_pin, cnt_pin, ack_a, ack_b, htrans} = '0;
		{haddr, hwdata, n_errors, tests_run} = '0;
		wait_n(20);
		rst_n <= 1'b1;
		wait_n(4);
		rdc(IDX_IRQ_MASK, RST_WORD);
		rdc(IDX_ASYNC_STATUS, RST_WORD);
		wr(8'h3f, 8'hff);
		rdc(8'h3f, RST_WORD);
		wr(IDX_CTRL_B, 8'hf8);
		rdc(IDX_CTRL_B, 32'h08);
		wr(IDX_CTRL_B, 8'h00);
		wr(IDX_IRQ_MASK, 8'h06);
		wr(IDX_AUX_CTRL, 8'h01);
		wr(IDX_CTRL_A, 8'h70);
		wr(IDX_CTRL_B, 8'hc0);
		wait_n(4);
		chk({30'h0, wave_a, wave_b}, 32'h3);
		chk({30'h0, irq_a, irq_b}, 32'h0);
		rdc(IDX_IRQ_FLAGS, 32'h0);
		rdc(IDX_CTRL_A, 32'h70);
		for (int k = 1; k < 8; k++)
		begin
			wr(IDX_CTRL_B, 8'h00);
			wr(IDX_COUNTER, 8'h00);
			wr(IDX_CTRL_B, 8'(k));
			wait_n(divs[k] * 20);
			rng(IDX_COUNTER, 8'd18, 8'd26);
		end
		wr(IDX_CTRL_B, 8'h00);
		bus(1'b0, IDX_COUNTER, 32'h0);
		hold = rd;
		wait_n(50);
		rdc(IDX_COUNTER, hold);
		wr(IDX_COUNTER, 8'h00);
		wr(IDX_IRQ_FLAGS, 8'h06);
		wr(IDX_CMP_A, 8'h05);
		wr(IDX_CMP_B, 8'h09);
		rdc(IDX_IRQ_FLAGS, 32'h0);
		wr(IDX_CTRL_B, 8'h01);
		wait_n(30);
		wr(IDX_CTRL_B, 8'h00);
		rdc(IDX_IRQ_FLAGS, 32'h06);
		chk({30'h0, irq_a, irq_b}, 32'h3);
		wr(IDX_IRQ_MASK, 8'h02);
		wait_n(3);
		chk({30'h0, irq_a, irq_b}, 32'h2);
		ack(1'b0);
		wait_n(3);
		rdc(IDX_IRQ_FLAGS, 32'h04);
		ack(1'b1);
		wait_n(3);
		rdc(IDX_IRQ_FLAGS, 32'h0);
		wr(IDX_COUNTER, 8'h05);
		wr(IDX_CTRL_B, 8'h03);
		wait_n(40);
		wr(IDX_CTRL_B, 8'h00);
		rdc(IDX_IRQ_FLAGS, 32'h0);
		wr(IDX_COUNTER, 8'h00);
		wr(IDX_AUX_CTRL, 8'h03);
		wr(IDX_CTRL_B, 8'h01);
		edges(1'b0, 5);
		wait_n(8);
		rdc(IDX_COUNTER, 32'h05);
		wr(IDX_CTRL_B, 8'h00);
		wr(IDX_AUX_CTRL, 8'h01);
		wr(IDX_CTRL_A, 8'h72);
		wr(IDX_CMP_A, 8'h03);
		wr(IDX_COUNTER, 8'h00);
		wr(IDX_CTRL_B, 8'h01);
		wait_n(40);
		wr(IDX_CTRL_B, 8'h00);
		rng(IDX_COUNTER, 8'd0, 8'd3);
		wr(IDX_CTRL_A, 8'h70);
		wr(IDX_ASYNC_STATUS, 8'h20);
		wait_n(3);
		chk({31'h0, xtal}, 32'h1);
		wr(IDX_ASYNC_STATUS, 8'h00);
		wr(IDX_ASYNC_STATUS, 8'h40);
		wr(IDX_ASYNC_STATUS, 8'h60);
		wait_n(3);
		chk({31'h0, xtal}, 32'h0);
		wr(IDX_COUNTER, 8'h00);
		wr(IDX_CMP_A, 8'h33);
		wr(IDX_CTRL_B, 8'h01);
		rdc(IDX_ASYNC_STATUS, 32'h79);
		rdc(IDX_CMP_A, 32'h33);
		edges(1'b1, 6);
		wait_n(8);
		rdc(IDX_ASYNC_STATUS, 32'h60);
		rng(IDX_COUNTER, 8'd3, 8'd6);
		conclude();
	end
endmodule // async_timer8_control_regs_bench
